// >>> rtl/ipc_params.svh
// ipc_params.svh: offsets, field positions, reset values for the interrupt priority control block
// assumes inclusion by both rtl files, the package and the priority block; definitions only
`ifndef IPC_PARAMS_SVH
`define IPC_PARAMS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define IPC_OFF_CAP_ADC_EXT   12'h000
`define IPC_OFF_TMR_CMP_DMA   12'h004
`define IPC_OFF_LVL_VEC       12'h008

// ------------------------------------------------------------
// field positions and widths
// ------------------------------------------------------------
`define IPC_PRIO_W            3
`define IPC_SLOT_STRIDE       4
`define IPC_LVL_LSB           8
`define IPC_LVL_W             4
`define IPC_VEC_W             7
`define IPC_NUM_SRC           8

// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define IPC_PRIO_RESET        3'h4
`define IPC_PRIO_OFF          3'h0
`define IPC_FIELD_MASK        16'h7777
`define IPC_VEC_BASE          7'h08

`endif

// >>> rtl/ipc_pkg.sv
// ipc_pkg.sv: types for the interrupt priority control block
// assumes ipc_params.svh is available on the include path
`include "ipc_params.svh"

package ipc_pkg;

    typedef logic [`IPC_PRIO_W-1:0] ipc_prio_t;

    // winning request toward the cpu core
    typedef struct packed {
        logic                   valid;
        logic [`IPC_LVL_W-1:0]  level;
        logic [`IPC_VEC_W-1:0]  vector;
    } ipc_req_s;

endpackage

// >>> rtl/ipc_prio_ctrl.sv
// ipc_prio_ctrl.sv: apb-mapped priority registers, arbitration and level/vector status
// assumes apb master on i_core_clk; cpu core supplies its current level and acks taken interrupts
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "ipc_params.svh"

module ipc_prio_ctrl #(
    parameter int NUM_SRC = `IPC_NUM_SRC
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    // apb slave
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [11:0]           i_paddr,
    input  wire logic [31:0]           i_pwdata,
    output logic      [31:0]           o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    // interrupt sources, level requests
    input  wire logic [NUM_SRC-1:0]    i_src_req,
    // cpu core side
    input  wire logic [`IPC_LVL_W-1:0] i_cpu_level,
    input  wire logic                  i_cpu_ack,
    output logic                       o_irq_valid,
    output logic      [`IPC_LVL_W-1:0] o_irq_level,
    output logic      [`IPC_VEC_W-1:0] o_irq_vector
);

    // ------------------------------------------------------------
    // priority storage
    // ------------------------------------------------------------
    // source order: 0 ext irq1, 1 adc2 done, 2 capture7, 3 capture8,
    // 4 dma ch2, 5 compare3, 6 compare4, 7 timer four
    ipc_pkg::ipc_prio_t prio_q [NUM_SRC];

    logic        setup_ph;
    logic        access_ph;
    logic        sel_reg0;
    logic        sel_reg1;
    logic        sel_stat;
    logic        addr_ok;
    logic        wr_reg0;
    logic        wr_reg1;
    logic [15:0] reg0_val;
    logic [15:0] reg1_val;
    logic [15:0] stat_val;
    logic [31:0] rdata_d;

    assign setup_ph  = i_psel & ~i_penable;
    assign access_ph = i_psel & i_penable;
    assign sel_reg0  = (i_paddr == `IPC_OFF_CAP_ADC_EXT);
    assign sel_reg1  = (i_paddr == `IPC_OFF_TMR_CMP_DMA);
    assign sel_stat  = (i_paddr == `IPC_OFF_LVL_VEC);
    assign addr_ok   = sel_reg0 | sel_reg1 | sel_stat;
    // writes commit on the first access cycle, when pready is high
    assign wr_reg0   = access_ph & o_pready & i_pwrite & sel_reg0;
    assign wr_reg1   = access_ph & o_pready & i_pwrite & sel_reg1;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_prio
            localparam int SLOT = g % 4;
            logic                 wr_slot;
            ipc_pkg::ipc_prio_t   wdata_slot;
            assign wr_slot    = (g < 4) ? wr_reg0 : wr_reg1;
            assign wdata_slot = i_pwdata[SLOT*`IPC_SLOT_STRIDE +: `IPC_PRIO_W];
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    prio_q[g] <= `IPC_PRIO_RESET;
                end else if (wr_slot) begin
                    prio_q[g] <= wdata_slot;
                end
            end
        end
    endgenerate

    // bit 3 of each nibble stays zero; writes there are dropped
    assign reg0_val = {1'b0, prio_q[3], 1'b0, prio_q[2], 1'b0, prio_q[1], 1'b0, prio_q[0]};
    assign reg1_val = {1'b0, prio_q[7], 1'b0, prio_q[6], 1'b0, prio_q[5], 1'b0, prio_q[4]};

    // ------------------------------------------------------------
    // per-source eligibility
    // ------------------------------------------------------------
    // both tests sit here so the scan below is a plain compare
    logic [NUM_SRC-1:0] src_on;
    logic [NUM_SRC-1:0] src_above;
    logic [NUM_SRC-1:0] src_elig;

    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_elig
            assign src_on[g]    = (prio_q[g] != `IPC_PRIO_OFF);
            assign src_above[g] = ({1'b0, prio_q[g]} > i_cpu_level);
            assign src_elig[g]  = i_src_req[g] & src_on[g] & src_above[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    ipc_pkg::ipc_req_s best;

    always_comb begin
        best = '0;
        // scan from highest index so lower vectors overwrite on a tie
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (src_elig[i] && (!best.valid || {1'b0, prio_q[i]} >= best.level)) begin
                best.valid  = 1'b1;
                best.level  = {1'b0, prio_q[i]};
                best.vector = `IPC_VEC_BASE + 7'(i);
            end
        end
    end

    // ------------------------------------------------------------
    // request to cpu and taken-interrupt status
    // ------------------------------------------------------------
    logic [`IPC_LVL_W-1:0] stat_lvl_q;
    logic [`IPC_VEC_W-1:0] stat_vec_q;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq_valid  <= 1'b0;
            o_irq_level  <= '0;
            o_irq_vector <= '0;
        end else begin
            o_irq_valid  <= best.valid;
            o_irq_level  <= best.level;
            o_irq_vector <= best.vector;
        end
    end

    // status latches the offered request when the cpu takes it
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            stat_lvl_q <= '0;
            stat_vec_q <= '0;
        end else if (i_cpu_ack && o_irq_valid) begin
            stat_lvl_q <= o_irq_level;
            stat_vec_q <= o_irq_vector;
        end
    end

    // status is read-only; a write is accepted and has no effect
    assign stat_val = {4'h0, stat_lvl_q, 1'b0, stat_vec_q};

    // ------------------------------------------------------------
    // apb answer: no wait state, read data registered
    // ------------------------------------------------------------
    assign rdata_d = sel_reg0 ? {16'h0, reg0_val} :
                     sel_reg1 ? {16'h0, reg1_val} :
                     sel_stat ? {16'h0, stat_val} : 32'h0;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_prdata  <= '0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= setup_ph;
            o_prdata  <= setup_ph ? rdata_d : 32'h0;
            o_pslverr <= setup_ph & ~addr_ok;
        end
    end

endmodule // ipc_prio_ctrl

// >>> verification/interrupt_priority_control_tb.sv
// bench: apb register checks and arbitration runs
// assumes checker and cpu model compiled first
`timescale 1ns/10ps
module interrupt_priority_control_tb;
    logic              clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, take = 0, rdy, err, vld, ack;
    logic [11:0]       pa = 12'h0;
    logic [31:0]       pwd = 32'h0, prd;
    logic [7:0]        req = 8'h0;
    logic [3:0]        setl = 4'h0, cpul, lvl;
    logic [6:0]        vec;
    ipc_pkg::ipc_req_s irq;
    int                miscompares = 0, check_count = 0;
    assign irq = {vld, lvl, vec};
    always #20 clk = ~clk;
    ipc_prio_ctrl ipc_prio_ctrl_i (.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pw),
        .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .i_src_req(req),
        .i_cpu_level(cpul), .i_cpu_ack(ack), .o_irq_valid(vld), .o_irq_level(lvl), .o_irq_vector(vec));
    ipc_cpu_model ipc_cpu_model_i (.i_core_clk(clk), .i_rst(rst), .i_set_level(setl), .i_take(take),
        .i_irq_valid(vld), .o_cpu_level(cpul), .o_cpu_ack(ack));
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
        @(posedge clk);
        psel <= 1'b1;
        pw   <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk);
        pen  <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        if (!w) chk({err, prd}, exp);
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    // cpu level passes the model first, hence three edges
    task automatic irq_is(input logic [11:0] exp);
        repeat (3) @(posedge clk);
        chk({21'h0, irq}, {21'h0, exp});
    endtask
    task automatic test_done;
        if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(0, 12'h000, 0, 33'h4444);
        apb(0, 12'h004, 0, 33'h4444);
        apb(1, 12'h008, 32'hffff, 0);
        apb(0, 12'h008, 0, 33'h0);
        apb(0, 12'h00c, 0, 33'h100000000);
        apb(1, 12'h004, 32'hffffffff, 0);
        apb(0, 12'h004, 0, 33'h7777);
        apb(1, 12'h004, 32'h1234, 0);
        for (int i = 4; i < 8; i++) begin
            req <= 8'hff << i;
            irq_is({1'b1, 4'(8 - i), 7'(8 + i)});
        end
        setl <= 4'h1;
        irq_is(12'h0);
        setl <= 4'h0;
        apb(1, 12'h000, 0, 0);
        req <= 8'h0f;
        irq_is(12'h0);
        apb(1, 12'h000, 32'h7777, 0);
        req <= 8'h0a;
        irq_is({1'b1, 4'h7, 7'h09});
        take <= 1'b1;
        @(posedge clk);
        take <= 1'b0;
        apb(0, 12'h008, 0, 33'h709);
        test_done;
    end
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        test_done;
    end
endmodule // interrupt_priority_control_tb

// >>> verification/ipc_cpu_model.sv
// cpu core model: holds its level, takes an offered interrupt
// assumes bench drives level and take right after clock edges
`timescale 1ns/10ps
module ipc_cpu_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [3:0] i_set_level,
    input  wire logic       i_take,
    input  wire logic       i_irq_valid,
    output logic      [3:0] o_cpu_level,
    output logic            o_cpu_ack
);
    // ack only against a standing offer, never in two cycles running
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cpu_level <= 4'h0;
            o_cpu_ack   <= 1'b0;
        end else begin
            o_cpu_level <= i_set_level;
            o_cpu_ack   <= i_take && i_irq_valid && !o_cpu_ack;
        end
    end
endmodule // ipc_cpu_model

// >>> verification/ipc_prio_ctrl_sva.sv
// checker: port assertions of the priority block
// assumes one clock domain, bound below
`timescale 1ns/10ps
module ipc_prio_ctrl_sva #(parameter int NUM_SRC = 8) (
    input wire logic               i_core_clk,
    input wire logic               i_rst,
    input wire logic               i_psel,
    input wire logic               i_penable,
    input wire logic [NUM_SRC-1:0] i_src_req,
    input wire logic [3:0]         i_cpu_level,
    input wire logic [31:0]        o_prdata,
    input wire logic               o_pready,
    input wire logic               o_pslverr,
    input wire logic               o_irq_valid,
    input wire logic [3:0]         o_irq_level,
    input wire logic [6:0]         o_irq_vector
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    a_ready_once: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready) else $error("pready");
    a_idle_zero: assert property (!o_pready |-> o_prdata == 32'h0) else $error("idle data");
    a_unused_zero: assert property (o_pready |-> o_prdata[31:15] == 17'h0 && !o_prdata[7]) else $error("unused");
    a_err_no_data: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0) else $error("slverr");
    a_above_cpu: assert property (o_irq_valid |-> o_irq_level > $past(i_cpu_level)) else $error("level");
    a_level_range: assert property (o_irq_valid |-> o_irq_level inside {[1:7]}) else $error("range");
    a_vector_base: assert property (o_irq_valid |-> o_irq_vector[6:3] == 4'h1) else $error("vector");
    a_src_asked: assert property (!$past(|i_src_req) |-> !o_irq_valid) else $error("no source");
    cover property (o_irq_valid && o_irq_level == 4'h7);
    cover property (o_pslverr);
    cover property (o_pready ##2 o_pready);
    cover property (o_irq_valid && o_irq_level == 4'h1);
endmodule // ipc_prio_ctrl_sva
bind ipc_prio_ctrl ipc_prio_ctrl_sva #(.NUM_SRC(NUM_SRC)) ipc_prio_ctrl_sva_i (.i_core_clk, .i_rst, .i_psel,
    .i_penable, .i_src_req, .i_cpu_level, .o_prdata, .o_pready, .o_pslverr, .o_irq_valid, .o_irq_level, .o_irq_vector);
